/* hw/tpc_defines.vh */
`ifndef TPC_DEFINES_VH
`define TPC_DEFINES_VH

// band select codes written by software
`define TPC_BAND_W 2
`define TPC_BAND_VHF 2'h0
`define TPC_BAND_HF 2'h1
`define TPC_BAND_MW 2'h2
`define TPC_BAND_OFF 2'h3

// port width and reset values
`define TPC_PORT_W 4
`define TPC_PORT_RST 4'h0
`define TPC_DIR_RST 4'h0

// phase error drive codes
`define TPC_PE_HIZ 2'h0
`define TPC_PE_LOW 2'h1
`define TPC_PE_HIGH 2'h2

`endif

/* hw/tpc_io_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defines.vh"

// one four-bit port: output latch, direction latch, registered readback
module tpc_io_port (
   input wire sys_clk,
   input wire rst_b,
   input wire hard_rst,
   input wire hold,
   input wire wr_data,
   input wire [3:0] data_in,
   input wire wr_dir,
   input wire [3:0] dir_in,
   input wire [3:0] pin_i,
   output reg [3:0] pin_o,
   output reg [3:0] pin_oe,
   output reg [3:0] rd_data
);
   // output and direction latches; hold freezes both
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_o <= `TPC_PORT_RST;
         pin_oe <= `TPC_DIR_RST;
      end else if (hard_rst) begin
         pin_o <= `TPC_PORT_RST; // RQ6
         pin_oe <= `TPC_DIR_RST; // RQ6
      end else if (!hold) begin
         if (wr_data) begin
            pin_o <= data_in; // RQ9
         end
         if (wr_dir) begin
            pin_oe <= dir_in; // RQ9
         end
      end
   end

   // readback shows latch for outputs, pin for inputs; pin_i arrives
   // already through two flops, so it may feed logic directly
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= 4'h0;
      end else begin
         rd_data <= (pin_oe & pin_o) | (~pin_oe & pin_i);
      end
   end
endmodule // tpc_io_port

`default_nettype wire

/* hw/tpc_port_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defines.vh"

// Overview of operation
// RQ1: bit port direction set per pin
// RQ2: group port direction set for all four
// RQ3: high-band input active only in VHF
// RQ4: low-band input active in HF or MW
// RQ5: phase error outputs high-z on resets, stop
// RQ6: I/O ports become inputs on hard resets
// RQ7: I/O ports held on chip-enable reset, stop
// RQ8: output-only port low on hard resets, held
// RQ9: held pins keep value and direction
module tpc_port_ctrl (
   input wire sys_clk,
   input wire rst_b,
   input wire watchdog_stack_reset,
   input wire ce_reset,
   input wire clk_stop,
   input wire [1:0] band_sel,
   input wire [1:0] phase_err_a_cmd,
   input wire [1:0] phase_err_b_cmd,
   input wire bit_wr_data,
   input wire bit_wr_dir,
   input wire [3:0] bit_data,
   input wire [3:0] bit_dir,
   input wire grp_wr_data,
   input wire grp_wr_dir,
   input wire [3:0] grp_data,
   input wire grp_dir_out,
   input wire shr_wr_data,
   input wire shr_wr_dir,
   input wire [3:0] shr_data,
   input wire [3:0] shr_dir,
   input wire oo_wr,
   input wire [3:0] oo_data,
   input wire [3:0] bitwise_dir_port_i,
   input wire [3:0] groupwise_dir_port_i,
   input wire [3:0] beeper_shared_port_i,
   output wire [3:0] bitwise_dir_port_o,
   output wire [3:0] bitwise_dir_port_oe,
   output wire [3:0] groupwise_dir_port_o,
   output wire [3:0] groupwise_dir_port_oe,
   output wire [3:0] beeper_shared_port_o,
   output wire [3:0] beeper_shared_port_oe,
   output wire [3:0] bit_rd,
   output wire [3:0] grp_rd,
   output wire [3:0] shr_rd,
   output reg [3:0] output_only_port,
   output reg high_band_osc_en,
   output reg low_band_osc_en,
   output reg phase_error_out_a_o,
   output reg phase_error_out_a_oe,
   output reg phase_error_out_b_o,
   output reg phase_error_out_b_oe
);
   ////////////////////////////////////////////////////////////////////
   // reset sources are async to sys_clk, so sync them first
   reg [1:0] wdt_sync_q;
   reg [1:0] ce_sync_q;
   reg [1:0] stop_sync_q;
   wire hard_rst;
   wire hold;

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wdt_sync_q <= 2'h0;
         ce_sync_q <= 2'h0;
         stop_sync_q <= 2'h0;
      end else begin
         wdt_sync_q <= {wdt_sync_q[0], watchdog_stack_reset};
         ce_sync_q <= {ce_sync_q[0], ce_reset};
         stop_sync_q <= {stop_sync_q[0], clk_stop};
      end
   end

   // power-on is rst_b itself; watchdog acts like it except on the oscillator enables and readback registers, which keep following band_sel and the pins
   // the synced watchdog lags by two edges, so a write that lands in
   // that window is cleared again on the third edge, when hard_rst takes effect
   // level inputs only; a pulse shorter than one clock may be missed
   assign hard_rst = wdt_sync_q[1];

   // chip-enable reset and clock stop share one freeze; a write
   // strobe seen while frozen is dropped, not deferred, so software
   // must repeat it once the freeze has lifted
   assign hold = ce_sync_q[1] | stop_sync_q[1]; // RQ7

   ////////////////////////////////////////////////////////////////////
   // pin levels come from the board, async to sys_clk; each bit passes
   // two flops before the readback logic may look at it
   wire [11:0] pin_raw;
   wire [11:0] pin_sync;
   genvar pin_idx;

   // bit port in [11:8], group port in [7:4], shared port in [3:0]
   assign pin_raw = {bitwise_dir_port_i, groupwise_dir_port_i,
      beeper_shared_port_i};

   generate
      for (pin_idx = 0; pin_idx < 12; pin_idx = pin_idx + 1) begin : g_pin
         reg meta_q;
         reg sync_q;

         // first flop may go metastable; only sync_q leaves this loop
         always @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
               meta_q <= 1'h0;
               sync_q <= 1'h0;
            end else begin
               meta_q <= pin_raw[pin_idx];
               sync_q <= meta_q;
            end
         end

         assign pin_sync[pin_idx] = sync_q;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // bidirectional ports
   // all three share the freeze and the hard reset, so their direction
   // latches always agree on when software may touch them
   tpc_io_port u_bit_port (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .hard_rst(hard_rst),
      .hold(hold),
      .wr_data(bit_wr_data),
      .data_in(bit_data),
      .wr_dir(bit_wr_dir),
      .dir_in(bit_dir), // RQ1
      .pin_i(pin_sync[11:8]),
      .pin_o(bitwise_dir_port_o),
      .pin_oe(bitwise_dir_port_oe),
      .rd_data(bit_rd)
   );

   // a single direction bit fans out to all four pins
   tpc_io_port u_grp_port (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .hard_rst(hard_rst),
      .hold(hold),
      .wr_data(grp_wr_data),
      .data_in(grp_data),
      .wr_dir(grp_wr_dir),
      .dir_in({4{grp_dir_out}}), // RQ2
      .pin_i(pin_sync[7:4]),
      .pin_o(groupwise_dir_port_o),
      .pin_oe(groupwise_dir_port_oe),
      .rd_data(grp_rd)
   );

   tpc_io_port u_shr_port (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .hard_rst(hard_rst),
      .hold(hold),
      .wr_data(shr_wr_data),
      .data_in(shr_data),
      .wr_dir(shr_wr_dir),
      .dir_in(shr_dir),
      .pin_i(pin_sync[3:0]),
      .pin_o(beeper_shared_port_o),
      .pin_oe(beeper_shared_port_oe),
      .rd_data(shr_rd)
   );

   ////////////////////////////////////////////////////////////////////
   // output-only port: low on hard reset, frozen while held
   // no direction latch here: these pins always drive
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         output_only_port <= `TPC_PORT_RST;
      end else if (hard_rst) begin
         output_only_port <= `TPC_PORT_RST; // RQ8
      end else if (oo_wr && !hold) begin
         output_only_port <= oo_data; // RQ8
      end
   end

   ////////////////////////////////////////////////////////////////////
   // oscillator input enables; low means the pin is pulled down
   // registered so the pulldown switch never glitches on band changes
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         high_band_osc_en <= 1'b0;
         low_band_osc_en <= 1'b0;
      end else begin
         high_band_osc_en <= (band_sel == `TPC_BAND_VHF); // RQ3
         low_band_osc_en <= (band_sel == `TPC_BAND_HF) ||
            (band_sel == `TPC_BAND_MW); // RQ4
      end
   end

   ////////////////////////////////////////////////////////////////////
   // phase error pair; any reset or stop forces high impedance
   // codes 0 and 3 both float the pin, so the loop filter simply
   // holds its voltage instead of being pulled either way
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_error_out_a_o <= 1'b0;
         phase_error_out_a_oe <= 1'b0;
         phase_error_out_b_o <= 1'b0;
         phase_error_out_b_oe <= 1'b0;
      end else if (hard_rst || hold) begin
         phase_error_out_a_oe <= 1'b0; // RQ5
         phase_error_out_b_oe <= 1'b0; // RQ5
         phase_error_out_a_o <= 1'b0;
         phase_error_out_b_o <= 1'b0;
      end else begin
         phase_error_out_a_oe <= (phase_err_a_cmd == `TPC_PE_LOW) ||
            (phase_err_a_cmd == `TPC_PE_HIGH);
         phase_error_out_a_o <= (phase_err_a_cmd == `TPC_PE_HIGH);
         phase_error_out_b_oe <= (phase_err_b_cmd == `TPC_PE_LOW) ||
            (phase_err_b_cmd == `TPC_PE_HIGH);
         phase_error_out_b_o <= (phase_err_b_cmd == `TPC_PE_HIGH);
      end
   end
endmodule // tpc_port_ctrl

`default_nettype wire

/* test/tpc_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// watches pin outputs against band, hold and reset inputs
module tpc_asserts (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic watchdog_stack_reset,
   input wire logic ce_reset,
   input wire logic clk_stop,
   input wire logic [1:0] band_sel,
   input wire logic [3:0] bitwise_dir_port_oe,
   input wire logic [3:0] groupwise_dir_port_oe,
   input wire logic [3:0] beeper_shared_port_oe,
   input wire logic [3:0] output_only_port,
   input wire logic high_band_osc_en,
   input wire logic low_band_osc_en,
   input wire logic phase_error_out_a_oe,
   input wire logic phase_error_out_b_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // four edges cover the two-stage sync plus the output register
   sequence s_hold;
      ((ce_reset || clk_stop) && !watchdog_stack_reset) [*4];
   endsequence
   sequence s_wd;
      watchdog_stack_reset [*4];
   endsequence
   a_high_band_en: assert property (1 |=>
      high_band_osc_en == ($past(band_sel) == 2'h0)) else $error("high band");
   a_low_band_en: assert property (1 |=>
      low_band_osc_en == ($past(band_sel) inside {2'h1, 2'h2}))
      else $error("low band");
   a_hold_pe_hiz: assert property (s_hold |->
      !phase_error_out_a_oe && !phase_error_out_b_oe) else $error("pe hold");
   a_wd_pe_hiz: assert property (s_wd |->
      !phase_error_out_a_oe && !phase_error_out_b_oe) else $error("pe wd");
   a_wd_all_inputs: assert property (s_wd |-> (bitwise_dir_port_oe |
      groupwise_dir_port_oe | beeper_shared_port_oe) == 4'h0)
      else $error("wd inputs");
   a_wd_oo_low: assert property (s_wd |-> output_only_port == 4'h0)
      else $error("wd oo");
   a_hold_keeps_pins: assert property (s_hold |=>
      $stable(output_only_port) && $stable(bitwise_dir_port_oe) &&
      $stable(groupwise_dir_port_oe)) else $error("hold changed");
   a_grp_dir_whole: assert property (groupwise_dir_port_oe inside
      {4'h0, 4'hF}) else $error("grp split");
endmodule // tpc_asserts
bind tpc_port_ctrl tpc_asserts u_chk (.*);
`default_nettype wire

/* test/tpc_board.sv */
`timescale 1ns/1ps
`default_nettype none
// board side: a driven bit reads back the device level, an undriven
// bit shows what the board puts there, never a stale drive value
module tpc_board (
   input wire logic [11:0] pin_o,
   input wire logic [11:0] pin_oe,
   input wire logic [11:0] board_lvl,
   output logic [11:0] pin_i
);
   assign pin_i = (pin_o & pin_oe) | (board_lvl & ~pin_oe);
endmodule // tpc_board
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic sys_clk, rst_b, watchdog_stack_reset, ce_reset, clk_stop;
   logic bit_wr_data, bit_wr_dir, grp_wr_data, grp_wr_dir, grp_dir_out;
   logic shr_wr_data, shr_wr_dir, oo_wr;
   logic [1:0] band_sel, phase_err_a_cmd, phase_err_b_cmd;
   logic [3:0] bit_data, bit_dir, grp_data, shr_data, shr_dir, oo_data, ext;
   logic [3:0] kd, ko;
   logic kg;
   wire [3:0] bitwise_dir_port_i, groupwise_dir_port_i, beeper_shared_port_i;
   wire [3:0] bitwise_dir_port_o, groupwise_dir_port_o, beeper_shared_port_o;
   wire [3:0] bitwise_dir_port_oe, groupwise_dir_port_oe;
   wire [3:0] beeper_shared_port_oe, bit_rd, grp_rd, shr_rd, output_only_port;
   wire high_band_osc_en, low_band_osc_en, phase_error_out_a_o;
   wire phase_error_out_a_oe, phase_error_out_b_o, phase_error_out_b_oe;
   integer err_total = 0, checked = 0, seed = 32'hE93F, cyc = 0, i;
   tpc_port_ctrl u_dut (.*);
   tpc_board u_board (
      .pin_o({bitwise_dir_port_o, groupwise_dir_port_o, beeper_shared_port_o}),
      .pin_oe({bitwise_dir_port_oe, groupwise_dir_port_oe,
         beeper_shared_port_oe}),
      .board_lvl({3{ext}}),
      .pin_i({bitwise_dir_port_i, groupwise_dir_port_i, beeper_shared_port_i}));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 0;
      forever #5 sys_clk = ~sys_clk;
   end
   // whole run is about 120 cycles, so 1000 means a hang
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 1000) begin
         err_total++;
         tally_and_finish;
      end
   end
   task automatic chk(input string n, input logic [3:0] s, e);
      checked++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic nx(input integer n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic wr(input logic v);
      {bit_wr_data, bit_wr_dir, grp_wr_data, grp_wr_dir, shr_wr_data,
         shr_wr_dir, oo_wr} = {7{v}};
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   function automatic logic [1:0] pe(input integer c);
      return {c == 1 || c == 2, c == 2};
   endfunction
   function automatic logic [3:0] rd(input logic [3:0] d, dr);
      return (d & dr) | (ext & ~dr);
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {watchdog_stack_reset, ce_reset, clk_stop, grp_dir_out, band_sel} = 0;
      {phase_err_a_cmd, phase_err_b_cmd, bit_data, bit_dir, grp_data} = 0;
      {shr_data, shr_dir, oo_data, ext} = 0;
      wr(0);
      rst_b = 0;
      nx(8);
      rst_b = 1;
      // every band code and phase drive code
      for (i = 0; i < 4; i++) begin
         band_sel = i[1:0];
         phase_err_a_cmd = i[1:0];
         phase_err_b_cmd = 2'h3 - i[1:0];
         nx(2);
         chk("band", {high_band_osc_en, low_band_osc_en},
            {i == 0, i == 1 || i == 2});
         chk("phase", {phase_error_out_a_oe, phase_error_out_a_o,
            phase_error_out_b_oe, phase_error_out_b_o}, {pe(i), pe(3 - i)});
      end
      $display("band test done");
      // random data, direction and board levels on every port
      for (i = 0; i < 12; i++) begin
         {bit_data, bit_dir, grp_data, grp_dir_out, oo_data, ext} = $random(seed);
         {shr_data, shr_dir} = {grp_data, ~bit_dir};
         wr(1);
         nx(1);
         wr(0);
         nx(4);
         chk("bit oe", bitwise_dir_port_oe, bit_dir);
         chk("bit rd", bit_rd, rd(bit_data, bit_dir));
         chk("grp oe", groupwise_dir_port_oe, {4{grp_dir_out}});
         chk("grp rd", grp_rd, rd(grp_data, {4{grp_dir_out}}));
         chk("shr rd", shr_rd, rd(shr_data, shr_dir));
         chk("oo", output_only_port, oo_data);
         chk("bit o", bitwise_dir_port_o, bit_data);
         chk("grp o", groupwise_dir_port_o, grp_data);
         chk("shr o", beeper_shared_port_o, shr_data);
         chk("shr oe", beeper_shared_port_oe, shr_dir);
      end
      $display("port test done");
      // clock stop, then chip-enable reset: writes must be dropped
      phase_err_a_cmd = 2'h2;
      for (i = 1; i < 3; i++) begin
         {ce_reset, clk_stop} = i[1:0];
         nx(4);
         chk("pe hold", {phase_error_out_a_oe, phase_error_out_b_oe}, 0);
         {kd, ko, kg} = {bit_dir, oo_data, grp_dir_out};
         {bit_dir, oo_data, grp_dir_out} = ~{kd, ko, kg};
         wr(1);
         nx(1);
         wr(0);
         nx(4);
         chk("bit held", bitwise_dir_port_oe, kd);
         chk("grp held", groupwise_dir_port_oe, {4{kg}});
         chk("oo held", output_only_port, ko);
         {bit_dir, oo_data, grp_dir_out} = {kd, ko, kg};
         {ce_reset, clk_stop} = 0;
         nx(4);
      end
      $display("hold test done");
      // watchdog reset while every port drives
      {bit_dir, grp_dir_out, oo_data, shr_dir} = 13'h1FFF;
      wr(1);
      nx(1);
      wr(0);
      nx(3);
      chk("wd pre", bitwise_dir_port_oe & groupwise_dir_port_oe &
         beeper_shared_port_oe & output_only_port, 4'hF);
      watchdog_stack_reset = 1;
      nx(4);
      chk("wd oe", bitwise_dir_port_oe | groupwise_dir_port_oe |
         beeper_shared_port_oe, 0);
      chk("wd oo", output_only_port, 0);
      chk("wd pe", {phase_error_out_a_oe, phase_error_out_b_oe}, 0);
      watchdog_stack_reset = 0;
      nx(4);
      $display("watchdog test done");
      // power-on reset in mid-run while every port drives
      band_sel = 2'h0;
      wr(1);
      nx(1);
      wr(0);
      nx(1);
      chk("por pre", bitwise_dir_port_oe & groupwise_dir_port_oe &
         beeper_shared_port_oe & output_only_port, 4'hF);
      rst_b = 0;
      nx(1);
      chk("por oe", bitwise_dir_port_oe | groupwise_dir_port_oe |
         beeper_shared_port_oe, 0);
      chk("por oo", output_only_port, 0);
      chk("por pe", {phase_error_out_a_oe, phase_error_out_b_oe}, 0);
      chk("por osc", {high_band_osc_en, low_band_osc_en}, 0);
      rst_b = 1;
      nx(1);
      chk("por in", bitwise_dir_port_oe | groupwise_dir_port_oe |
         beeper_shared_port_oe, 0);
      chk("por band", {high_band_osc_en, low_band_osc_en}, 2'h2);
      chk("por drv", {phase_error_out_a_oe, phase_error_out_a_o},
         pe(2));
      $display("reset test done");
      tally_and_finish;
   end
endmodule // testbench
`default_nettype wire
